/* logic/ctb_bank.sv */
/*
 * Converter tuning command bank: manufacturer command registers and the small pieces of
 * control logic they steer (power-good polarity, fast overcurrent trip, fault delay timers,
 * pre-bias slope check, filter select, kickstart pre-trigger count).
 * Assumes a bus front end that presents each decoded transfer as one-cycle strobes with the
 * whole little-endian payload, and analog measurements already digitised and synchronous.
 */
`timescale 1ns/1ps
// Behaviour
// - Hold eight-bit remote-control threshold at C6.
// - Pretrigger 20 us plus 450 ns per step.
// - Add offset to input turnoff level.
// - Power-good low for 0, high for 1.
// - Require bits 12:8 samples before trip.
// - Compare current with seven-bit trip level.
// - Bit 7 enables fast overcurrent.
// - Unit codes: 1 ms, 10 ms, 100 ms, 1 s.
// - Unit fields: vout, vin, iout, temperature.
// - Fault delay is count times category unit.
// - Scale monitor read: on offset high, off scale low.
// - Input slope limits gate pre-bias start.
// - Output slope limits gate pre-bias start.
// - Filter index: vout, iout, feedforward.
module ctb_bank
    import ctb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Decoded command transfers
    input wire logic [7:0] cmd_code,
    input wire logic [3:0] cmd_len,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [63:0] cmd_wdata,
    output logic [63:0] cmd_rdata,
    output logic cmd_ack,
    output logic cmd_err,
    // Trimmed input scale values
    input wire logic [15:0] trim_offset_on,
    input wire logic [15:0] trim_scale_off,
    // Measurements
    input wire logic [7:0] remote_ctrl_analog_pin,
    input wire logic [7:0] input_voltage,
    input wire logic [7:0] input_turnoff_level,
    input wire logic [6:0] current_level,
    input wire logic oc_sample_strobe,
    input wire logic signed [15:0] vin_slope,
    input wire logic signed [15:0] vout_slope,
    input wire logic power_good_state,
    // Fault delay timers, one per category: vout, vin, iout, temperature
    input wire logic [3:0] fault_delay_start,
    input wire logic [31:0] fault_delay_count,
    output logic [3:0] fault_delay_done,
    // Controls
    output logic remote_ctrl_trigger,
    output logic fast_input_off,
    output logic power_good_pin,
    output logic fast_oc_trip,
    output logic prebias_allowed,
    output logic [2:0] filter_onehot,
    output logic [13:0] pretrig_cycles
);
    import ctb_pkg::*;

    // ----------------------------------------------------------------
    // Unit decode, used for all four categories
    // ----------------------------------------------------------------
    function automatic logic [9:0] unit_ms(input logic [1:0] code);
        unique case (ctb_unit_t'(code))
            CTB_UNIT_1MS: unit_ms = UNIT_1MS_MS;
            CTB_UNIT_10MS: unit_ms = UNIT_10MS_MS;
            CTB_UNIT_100MS: unit_ms = UNIT_100MS_MS;
            CTB_UNIT_1S: unit_ms = UNIT_1S_MS;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] rc_thr_q, rc_thr_d;
    logic [7:0] pretrig_q, pretrig_d;
    logic [7:0] in_off_q, in_off_d;
    logic [7:0] pg_pol_q, pg_pol_d;
    logic [15:0] oc_cfg_q, oc_cfg_d;
    logic [7:0] unit_q, unit_d;
    logic [63:0] slope_q, slope_d;
    logic [7:0] filt_q, filt_d;
    logic [63:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic err_q, err_d;
    logic len_ok;
    logic known;

    always_comb begin
        rc_thr_d = rc_thr_q;
        pretrig_d = pretrig_q;
        in_off_d = in_off_q;
        pg_pol_d = pg_pol_q;
        oc_cfg_d = oc_cfg_q;
        unit_d = unit_q;
        slope_d = slope_q;
        filt_d = filt_q;
        rdata_d = 64'h0;
        known = 1'b1;
        // Length follows the command's transfer type; a mismatch is refused whole
        unique case (cmd_code)
            CMD_FAST_OC_CFG: len_ok = (cmd_len == LEN_WORD);
            CMD_IN_SCALE_MON: len_ok = (cmd_len == LEN_MON) && !cmd_wr;
            CMD_PREBIAS_SLOPE: len_ok = (cmd_len == LEN_SLOPE);
            default: len_ok = (cmd_len == LEN_BYTE);
        endcase
        unique case (cmd_code)
            CMD_RC_THRESHOLD: rdata_d[7:0] = rc_thr_q;
            CMD_KS_PRETRIG: rdata_d[7:0] = pretrig_q;
            CMD_FAST_IN_OFF: rdata_d[7:0] = in_off_q;
            CMD_PG_POLARITY: rdata_d[7:0] = pg_pol_q;
            CMD_FAST_OC_CFG: rdata_d[15:0] = oc_cfg_q;
            CMD_DELAY_UNIT: rdata_d[7:0] = unit_q;
            CMD_IN_SCALE_MON: rdata_d[31:0] = {trim_offset_on, trim_scale_off};
            CMD_PREBIAS_SLOPE: rdata_d = slope_q;
            CMD_FILTER_SEL: rdata_d[7:0] = filt_q;
            default: known = 1'b0;
        endcase
        if (cmd_wr && known && len_ok) begin
            unique case (cmd_code)
                CMD_RC_THRESHOLD: rc_thr_d = cmd_wdata[7:0];
                CMD_KS_PRETRIG: pretrig_d = cmd_wdata[7:0];
                CMD_FAST_IN_OFF: in_off_d = cmd_wdata[7:0];
                CMD_PG_POLARITY: pg_pol_d = cmd_wdata[7:0];
                CMD_FAST_OC_CFG: oc_cfg_d = cmd_wdata[15:0] & OC_WRITE_MASK;
                CMD_DELAY_UNIT: unit_d = cmd_wdata[7:0];
                CMD_PREBIAS_SLOPE: slope_d = cmd_wdata;
                CMD_FILTER_SEL: filt_d = cmd_wdata[7:0];
                default: ;
            endcase
        end
        if (!cmd_rd || !known || !len_ok) begin
            rdata_d = 64'h0;
        end
        ack_d = (cmd_wr || cmd_rd) && known && len_ok;
        err_d = (cmd_wr || cmd_rd) && !(known && len_ok);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rc_thr_q <= RST_BYTE;
            pretrig_q <= RST_BYTE;
            in_off_q <= RST_BYTE;
            pg_pol_q <= PG_ACTIVE_LOW;
            oc_cfg_q <= RST_OC_CFG;
            unit_q <= RST_BYTE;
            slope_q <= RST_SLOPE;
            filt_q <= FILT_VOUT;
            rdata_q <= 64'h0;
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rc_thr_q <= rc_thr_d;
            pretrig_q <= pretrig_d;
            in_off_q <= in_off_d;
            pg_pol_q <= pg_pol_d;
            oc_cfg_q <= oc_cfg_d;
            unit_q <= unit_d;
            slope_q <= slope_d;
            filt_q <= filt_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            err_q <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // Protection and control outputs
    // ----------------------------------------------------------------
    logic [4:0] oc_cnt_q, oc_cnt_d;
    logic rc_q, rc_d, fio_q, fio_d, pg_q, pg_d, oct_q, oct_d, pb_q, pb_d;
    logic [2:0] filt_oh_q, filt_oh_d;
    logic [13:0] pre_q, pre_d;
    logic [8:0] off_sum;
    logic oc_en;
    logic oc_over;

    always_comb begin
        oc_en = oc_cfg_q[OC_ENABLE_BIT];
        oc_over = current_level >= oc_cfg_q[OC_LEVEL_MSB:0];
        oc_cnt_d = oc_cnt_q;
        oct_d = oct_q;
        if (!oc_en) begin
            oc_cnt_d = 5'h0;
            oct_d = 1'b0;
        end else if (oc_sample_strobe) begin
            if (!oc_over) begin
                oc_cnt_d = 5'h0;
                oct_d = 1'b0;
            end else if (oc_cnt_q + 5'h1 >= oc_cfg_q[OC_SAMPLES_MSB:OC_SAMPLES_LSB]) begin
                oct_d = 1'b1;
            end else begin
                oc_cnt_d = oc_cnt_q + 5'h1;
            end
        end
        rc_d = remote_ctrl_analog_pin >= rc_thr_q;
        off_sum = {1'b0, input_turnoff_level} + {1'b0, in_off_q};
        fio_d = {1'b0, input_voltage} < off_sum;
        // Only code 01 drives the pin active high; any other value leaves the pin active low
        pg_d = (pg_pol_q == PG_ACTIVE_HIGH) ? power_good_state : !power_good_state;
        pb_d = (vin_slope <= $signed(slope_q[SLOPE_VIN_POS_LSB +: 16]))
            && (vin_slope >= -$signed(slope_q[SLOPE_VIN_NEG_LSB +: 16]))
            && (vout_slope <= $signed(slope_q[SLOPE_VOUT_POS_LSB +: 16]))
            && (vout_slope >= -$signed(slope_q[SLOPE_VOUT_NEG_LSB +: 16]));
        unique case (filt_q)
            FILT_VOUT: filt_oh_d = 3'b001;
            FILT_IOUT: filt_oh_d = 3'b010;
            FILT_FEEDFWD: filt_oh_d = 3'b100;
            default: filt_oh_d = 3'b000;
        endcase
        pre_d = 14'(PRETRIG_BASE_CYC) + 14'(pretrig_q) * 14'(PRETRIG_STEP_CYC);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            oc_cnt_q <= 5'h0;
            oct_q <= 1'b0;
            rc_q <= 1'b0;
            fio_q <= 1'b0;
            pg_q <= 1'b0;
            pb_q <= 1'b0;
            filt_oh_q <= 3'b001;
            pre_q <= 14'(PRETRIG_BASE_CYC);
        end else begin
            oc_cnt_q <= oc_cnt_d;
            oct_q <= oct_d;
            rc_q <= rc_d;
            fio_q <= fio_d;
            pg_q <= pg_d;
            pb_q <= pb_d;
            filt_oh_q <= filt_oh_d;
            pre_q <= pre_d;
        end
    end

    // ----------------------------------------------------------------
    // Fault delay timers: shared 1 ms tick, per-category unit and count
    // ----------------------------------------------------------------
    logic [15:0] tick_q, tick_d;
    logic ms_tick;

    always_comb begin
        ms_tick = (tick_q == 16'(TICK_1MS_CYC - 1));
        tick_d = ms_tick ? 16'h0 : tick_q + 16'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tick_q <= 16'h0;
        end else begin
            tick_q <= tick_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_tmr
            // Category 0 is vout (bits 7:6) down to category 3 temperature (bits 1:0)
            logic [9:0] ms_q, ms_d;
            logic [7:0] cnt_q, cnt_d;
            logic run_q, run_d, done_q, done_d;
            logic [1:0] ucode;
            always_comb begin
                ucode = unit_q[UNIT_VOUT_LSB - 2 * g +: 2];
                ms_d = ms_q;
                cnt_d = cnt_q;
                run_d = run_q;
                done_d = 1'b0;
                if (fault_delay_start[g]) begin
                    // Unit loaded at start and reloaded from the current code at each count step, so a later rewrite changes a running delay
                    ms_d = unit_ms(ucode);
                    cnt_d = fault_delay_count[8 * g +: 8];
                    run_d = (fault_delay_count[8 * g +: 8] != 8'h0);
                    done_d = (fault_delay_count[8 * g +: 8] == 8'h0);
                end else if (run_q && ms_tick) begin
                    if (ms_q > 10'h001) begin
                        ms_d = ms_q - 10'h001;
                    end else if (cnt_q > 8'h01) begin
                        cnt_d = cnt_q - 8'h01;
                        ms_d = unit_ms(ucode);
                    end else begin
                        run_d = 1'b0;
                        done_d = 1'b1;
                    end
                end
            end
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    ms_q <= 10'h0;
                    cnt_q <= 8'h0;
                    run_q <= 1'b0;
                    done_q <= 1'b0;
                end else begin
                    ms_q <= ms_d;
                    cnt_q <= cnt_d;
                    run_q <= run_d;
                    done_q <= done_d;
                end
            end
            assign fault_delay_done[g] = done_q;
        end
    endgenerate

    assign cmd_rdata = rdata_q;
    assign cmd_ack = ack_q;
    assign cmd_err = err_q;
    assign remote_ctrl_trigger = rc_q;
    assign fast_input_off = fio_q;
    assign power_good_pin = pg_q;
    assign fast_oc_trip = oct_q;
    assign prebias_allowed = pb_q;
    assign filter_onehot = filt_oh_q;
    assign pretrig_cycles = pre_q;
endmodule // ctb_bank

/* logic/ctb_pkg.sv */
/*
 * Shared constants for the converter tuning command bank: command codes, field positions,
 * reset values and timing counts.
 * Assumes a 40 MHz core clock and a management-bus front end that decodes transfers.
 */
package ctb_pkg;
    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_RC_THRESHOLD = 8'hC6;
    localparam logic [7:0] CMD_KS_PRETRIG = 8'hC7;
    localparam logic [7:0] CMD_FAST_IN_OFF = 8'hC8;
    localparam logic [7:0] CMD_PG_POLARITY = 8'hD0;
    localparam logic [7:0] CMD_FAST_OC_CFG = 8'hD1;
    localparam logic [7:0] CMD_DELAY_UNIT = 8'hD2;
    localparam logic [7:0] CMD_IN_SCALE_MON = 8'hD3;
    localparam logic [7:0] CMD_PREBIAS_SLOPE = 8'hD4;
    localparam logic [7:0] CMD_FILTER_SEL = 8'hD5;

    // ----------------------------------------------------------------
    // Transfer lengths in bytes
    // ----------------------------------------------------------------
    localparam logic [3:0] LEN_BYTE = 4'h1;
    localparam logic [3:0] LEN_WORD = 4'h2;
    localparam logic [3:0] LEN_MON = 4'h4;
    localparam logic [3:0] LEN_SLOPE = 4'h8;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int OC_SAMPLES_MSB = 12;
    localparam int OC_SAMPLES_LSB = 8;
    localparam int OC_ENABLE_BIT = 7;
    localparam int OC_LEVEL_MSB = 6;
    localparam logic [15:0] OC_WRITE_MASK = 16'h1FFF;
    localparam int UNIT_VOUT_LSB = 6;
    localparam int UNIT_VIN_LSB = 4;
    localparam int UNIT_IOUT_LSB = 2;
    localparam int UNIT_TEMP_LSB = 0;
    localparam int SLOPE_VIN_POS_LSB = 48;
    localparam int SLOPE_VIN_NEG_LSB = 32;
    localparam int SLOPE_VOUT_POS_LSB = 16;
    localparam int SLOPE_VOUT_NEG_LSB = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_OC_CFG = 16'h0000;
    localparam logic [63:0] RST_SLOPE = 64'h0000_0000_0000_0000;
    localparam logic [7:0] PG_ACTIVE_LOW = 8'h00;
    localparam logic [7:0] PG_ACTIVE_HIGH = 8'h01;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int PRETRIG_BASE_NS = 20000;
    localparam int PRETRIG_STEP_NS = 450;
    localparam int PRETRIG_BASE_CYC = PRETRIG_BASE_NS * CLK_MHZ / 1000;
    // 450 ns is exactly 18 cycles at 40 MHz
    localparam int PRETRIG_STEP_CYC = PRETRIG_STEP_NS * CLK_MHZ / 1000;
    localparam int MS_US = 1000;
    localparam int TICK_1MS_CYC = MS_US * CLK_MHZ;
    // Milliseconds per delay unit code
    localparam logic [9:0] UNIT_1MS_MS = 10'h001;
    localparam logic [9:0] UNIT_10MS_MS = 10'h00A;
    localparam logic [9:0] UNIT_100MS_MS = 10'h064;
    localparam logic [9:0] UNIT_1S_MS = 10'h3E8;

    // Delay unit codes
    typedef enum logic [1:0] {
        CTB_UNIT_1MS = 2'b00,
        CTB_UNIT_10MS = 2'b01,
        CTB_UNIT_100MS = 2'b10,
        CTB_UNIT_1S = 2'b11
    } ctb_unit_t;

    // Filter selection codes
    localparam logic [7:0] FILT_VOUT = 8'h00;
    localparam logic [7:0] FILT_IOUT = 8'h01;
    localparam logic [7:0] FILT_FEEDFWD = 8'h02;
endpackage

/* test/ctb_bank_sva.sv */
/*
 * Checker for the tuning command bank: transfer answers and control outputs.
 * Bound to ctb_bank; sees its ports only.
 */
`timescale 1ns/1ps
module ctb_bank_sva
    import ctb_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Transfers
    input wire logic [7:0] cmd_code,
    input wire logic [3:0] cmd_len,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [63:0] cmd_rdata,
    input wire logic cmd_ack,
    input wire logic cmd_err,
    input wire logic [15:0] trim_offset_on,
    input wire logic [15:0] trim_scale_off,
    // Controls
    input wire logic oc_sample_strobe,
    input wire logic fast_oc_trip,
    input wire logic [3:0] fault_delay_start,
    input wire logic [31:0] fault_delay_count,
    input wire logic [3:0] fault_delay_done,
    input wire logic [2:0] filter_onehot,
    input wire logic [13:0] pretrig_cycles
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_byte_ack: assert property (cmd_wr && cmd_code == CMD_RC_THRESHOLD &&
        cmd_len == LEN_BYTE |=> cmd_ack && !cmd_err) else $error("byte write not acked");
    chk_ro_refuse: assert property (cmd_wr && cmd_code == CMD_IN_SCALE_MON |=>
        cmd_err && !cmd_ack && cmd_rdata == 64'h0) else $error("monitor write accepted");
    chk_word_len: assert property ((cmd_wr || cmd_rd) && cmd_code == CMD_FAST_OC_CFG &&
        cmd_len != LEN_WORD |=> cmd_err) else $error("bad word length accepted");
    chk_mon_read: assert property (cmd_rd && cmd_code == CMD_IN_SCALE_MON &&
        cmd_len == LEN_MON |=> cmd_ack && cmd_rdata ==
        {32'h0, $past(trim_offset_on), $past(trim_scale_off)}) else $error("monitor read");
    chk_oc_reserved: assert property (cmd_rd && cmd_code == CMD_FAST_OC_CFG |=>
        cmd_rdata[63:13] == 51'h0) else $error("reserved bits nonzero");
    chk_rdata_idle: assert property (!cmd_ack |-> cmd_rdata == 64'h0)
        else $error("read data outside ack");
    chk_filter_hot: assert property ($onehot0(filter_onehot))
        else $error("filter select not one-hot");
    chk_trip_sample: assert property ($rose(fast_oc_trip) |-> $past(oc_sample_strobe))
        else $error("trip without sample");
    chk_pretrig_step: assert property (pretrig_cycles >= 14'h320 &&
        (pretrig_cycles - 14'h320) % 18 == 0) else $error("pretrigger count off grid");
    chk_zero_count: assert property (fault_delay_start[2] &&
        fault_delay_count[23:16] == 8'h00 |=> fault_delay_done[2]) else $error("zero delay");
    chk_done_pulse: assert property (|fault_delay_done |=>
        (fault_delay_done & $past(fault_delay_done)) == 4'h0) else $error("done too long");

    cov_write: cover property (cmd_wr ##1 cmd_ack);
    cov_mon: cover property (cmd_rd && cmd_code == CMD_IN_SCALE_MON ##1 cmd_ack);
    cov_trip: cover property ($rose(fast_oc_trip));
endmodule // ctb_bank_sva

bind ctb_bank ctb_bank_sva u_sva (.*);

/* test/ctb_bank_tb.sv */
/*
 * Self-checking bench for the tuning command bank.
 * Assumes the host model in ctb_host_model and the checker bound by ctb_bank_sva.
 */
`timescale 1ns/1ps
module ctb_bank_tb;
    import ctb_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] cmd_code, remote_ctrl_analog_pin, input_voltage, input_turnoff_level;
    logic [3:0] cmd_len, fault_delay_start, fault_delay_done;
    logic cmd_wr, cmd_rd, cmd_ack, cmd_err, oc_sample_strobe, power_good_state;
    logic [63:0] cmd_wdata, cmd_rdata, rd_v;
    logic [15:0] trim_offset_on, trim_scale_off;
    logic signed [15:0] vin_slope, vout_slope;
    logic [6:0] current_level;
    logic [31:0] fault_delay_count;
    logic remote_ctrl_trigger, fast_input_off, power_good_pin, fast_oc_trip, prebias_allowed;
    logic [2:0] filter_onehot;
    logic [13:0] pretrig_cycles;
    logic [1:0] ae_v;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    ctb_bank dut (.*);
    ctb_host_model host (.*);

    always #12.5 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict;
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] c, input logic [3:0] n, input logic [63:0] d);
        host.xfer(1'b1, c, n, d, rd_v, ae_v);
        check(ae_v === 2'b10, "write refused");
    endtask
    task automatic rdc(input logic [7:0] c, input logic [3:0] n, input logic [63:0] e);
        host.xfer(1'b0, c, n, 64'h0, rd_v, ae_v);
        check(ae_v === 2'b10 && rd_v === e, "read data");
    endtask
    task automatic bad(input logic w, input logic [7:0] c, input logic [3:0] n);
        host.xfer(w, c, n, 64'hFF, rd_v, ae_v);
        check(ae_v === 2'b01 && rd_v === 64'h0, "transfer not refused");
    endtask
    task automatic lvl(input logic [7:0] a, v, t, input logic r, f);
        remote_ctrl_analog_pin = a;
        input_voltage = v;
        input_turnoff_level = t;
        repeat (3) @(negedge ref_clk);
        check(remote_ctrl_trigger === r && fast_input_off === f, "level compare");
    endtask
    task automatic strobe;
        oc_sample_strobe = 1'b1;
        @(negedge ref_clk);
        oc_sample_strobe = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic sl(input logic signed [15:0] vi, vo, input logic e);
        vin_slope = vi;
        vout_slope = vo;
        repeat (3) @(negedge ref_clk);
        check(prebias_allowed === e, "prebias gate");
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0] cd [6];
        cd = '{CMD_RC_THRESHOLD, CMD_KS_PRETRIG, CMD_FAST_IN_OFF, CMD_PG_POLARITY,
            CMD_DELAY_UNIT, CMD_FILTER_SEL};
        rdc(CMD_RC_THRESHOLD, LEN_BYTE, 64'h0);
        check(pretrig_cycles === 14'(20000 / 25), "pretrigger after reset");
        for (int i = 0; i < 6; i++) begin
            wr(cd[i], LEN_BYTE, 64'h5A + 64'(i));
            rdc(cd[i], LEN_BYTE, 64'h5A + 64'(i));
        end
        wr(CMD_FAST_OC_CFG, LEN_WORD, 64'hFFFF);
        rdc(CMD_FAST_OC_CFG, LEN_WORD, 64'h1FFF);
        wr(CMD_PREBIAS_SLOPE, LEN_SLOPE, 64'h8001_7FFE_0123_FEDC);
        bad(1'b1, CMD_PREBIAS_SLOPE, LEN_BYTE);
        rdc(CMD_PREBIAS_SLOPE, LEN_SLOPE, 64'h8001_7FFE_0123_FEDC);
        rdc(CMD_IN_SCALE_MON, LEN_MON, 64'h1234_ABCD);
        bad(1'b1, CMD_IN_SCALE_MON, LEN_MON);
        bad(1'b0, CMD_RC_THRESHOLD, LEN_WORD);
        bad(1'b0, 8'hD6, LEN_BYTE);
    endtask
    task automatic t_ctrl;
        for (int p = 0; p < 2; p++) begin
            wr(CMD_PG_POLARITY, LEN_BYTE, 64'(p));
            for (int s = 0; s < 2; s++) begin
                power_good_state = s[0];
                repeat (3) @(negedge ref_clk);
                check(power_good_pin === (s[0] ~^ p[0]), "power good level");
            end
        end
        for (int i = 0; i < 4; i++) begin
            wr(CMD_FILTER_SEL, LEN_BYTE, 64'(i));
            repeat (2) @(negedge ref_clk);
            check(filter_onehot === (i < 3 ? 3'h1 << i : 3'h0), "filter select");
        end
        for (int v = 0; v < 256; v += 127) begin
            wr(CMD_KS_PRETRIG, LEN_BYTE, 64'(v));
            repeat (2) @(negedge ref_clk);
            check(pretrig_cycles === 14'(20000 / 25 + v * 450 / 25), "pretrigger");
        end
        wr(CMD_RC_THRESHOLD, LEN_BYTE, 64'h80);
        wr(CMD_FAST_IN_OFF, LEN_BYTE, 64'h10);
        lvl(8'h80, 8'h4F, 8'h40, 1'b1, 1'b1);
        lvl(8'h7F, 8'h50, 8'h40, 1'b0, 1'b0);
        lvl(8'h00, 8'hFF, 8'hF8, 1'b0, 1'b1);
    endtask
    task automatic t_oc;
        wr(CMD_FAST_OC_CFG, LEN_WORD, 64'h03A0);
        current_level = 7'h21;
        for (int i = 1; i <= 3; i++) begin
            strobe();
            check(fast_oc_trip === (i == 3), "trip sample count");
        end
        current_level = 7'h1F;
        strobe();
        check(fast_oc_trip === 1'b0, "trip below level");
        wr(CMD_FAST_OC_CFG, LEN_WORD, 64'h0320);
        current_level = 7'h30;
        repeat (4) strobe();
        check(fast_oc_trip === 1'b0, "trip while disabled");
    endtask
    task automatic t_slope;
        wr(CMD_PREBIAS_SLOPE, LEN_SLOPE, 64'h0064_0064_0064_0064);
        sl(16'sh0032, -16'sh0032, 1'b1);
        sl(16'sh0096, 16'sh0000, 1'b0);
        sl(-16'sh0096, 16'sh0000, 1'b0);
        sl(16'sh0000, 16'sh0096, 1'b0);
        sl(16'sh0000, -16'sh0096, 1'b0);
    endtask
    task automatic t_delay;
        logic [3:0] seen;
        seen = 4'h0;
        wr(CMD_DELAY_UNIT, LEN_BYTE, 64'h1B);
        fault_delay_count = 32'h0100_0101;
        fault_delay_start = 4'hF;
        @(negedge ref_clk);
        // A zero-count done stands only in this cycle
        seen = fault_delay_done;
        fault_delay_start = 4'h0;
        for (int c = 0; c < 40005; c++) begin
            @(negedge ref_clk);
            seen = seen | fault_delay_done;
            if (c == 2) check(seen === 4'h4, "zero count delay");
        end
        check(seen === 4'h5, "delay units by category");
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 50000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        trim_offset_on = 16'h1234;
        trim_scale_off = 16'hABCD;
        remote_ctrl_analog_pin = 8'h00;
        input_voltage = 8'hFF;
        input_turnoff_level = 8'h00;
        current_level = 7'h00;
        oc_sample_strobe = 1'b0;
        vin_slope = 16'sh0000;
        vout_slope = 16'sh0000;
        power_good_state = 1'b0;
        fault_delay_start = 4'h0;
        fault_delay_count = 32'h0;
        repeat (20) @(negedge ref_clk);
        rstn = 1'b1;
        t_regs();
        t_ctrl();
        t_oc();
        t_slope();
        t_delay();
        give_verdict();
    end
endmodule // ctb_bank_tb

/* test/ctb_host_model.sv */
/*
 * Host model: issues byte, word and block transfers on the decoded command port.
 * Assumes the bank takes a request on the rising edge and answers one cycle later.
 */
`timescale 1ns/1ps
module ctb_host_model (
    // Clock
    input wire logic ref_clk,
    // Request
    output logic [7:0] cmd_code,
    output logic [3:0] cmd_len,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic [63:0] cmd_wdata,
    // Answer
    input wire logic [63:0] cmd_rdata,
    input wire logic cmd_ack,
    input wire logic cmd_err
);
    initial begin
        cmd_code = 8'h00;
        cmd_len = 4'h0;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = 64'h0;
    end

    // One transfer: the length goes with the code, as the host must send it
    task automatic xfer(input logic w, input logic [7:0] c, input logic [3:0] n,
            input logic [63:0] d, output logic [63:0] rd, output logic [1:0] ae);
        @(negedge ref_clk);
        cmd_code = c;
        cmd_len = n;
        cmd_wr = w;
        cmd_rd = !w;
        cmd_wdata = d;
        @(negedge ref_clk);
        rd = cmd_rdata;
        ae = {cmd_ack, cmd_err};
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        // Released payload must not keep looking valid
        cmd_wdata = ~d;
    endtask
endmodule // ctb_host_model
